//--- inc/asr_pkg.sv
// constants for the host-side controller of a 2048 x 8 asynchronous static ram
// assumes a 20 MHz mclk; all strobe timing is counted in mclk cycles
//
// Behaviour
// - Eleven address lines pick the location, held steady per access.
// - The host keeps output gate high in writes to avoid a driver fight.
// - The host never drives the pins while the memory is reading out.
// - Chips float when deselected, so a bus holds several, one enabled.
package asr_pkg;
	localparam int ADDR_W       = 11;
	localparam int DATA_W       = 8;
	localparam int CLK_PERIOD_NS = 50;
	// access and pulse times in ns
	localparam int READ_ACC_NS  = 200;
	localparam int WR_PULSE_NS  = 120;
	localparam int WR_SETUP_NS  = 60;
	localparam int RECOVERY_NS  = 10;
	localparam int DISABLE_NS   = 60;
	// minimum times round up
	localparam int READ_CYC  = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRP_CYC   = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_CYC   = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIS_CYC   = (DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W     = 4;

	typedef enum logic [5:0] {
		ASR_IDLE  = 6'b00_0001,
		ASR_RSTRB = 6'b00_0010,
		ASR_RDONE = 6'b00_0100,
		ASR_WSTRB = 6'b00_1000,
		ASR_WEND  = 6'b01_0000,
		ASR_GAP   = 6'b10_0000
	} asr_state_t;
endpackage : asr_pkg

//--- rtl/asr_host.sv
// host controller that drives a 2048 x 8 asynchronous static ram
// user side: one request at a time, read or write, with a done pulse
// assumes the memory sits directly on the pins and no other master is present
`timescale 1ns/10ps
`default_nettype none
module asr_host #(
	parameter int ADDR_W = asr_pkg::ADDR_W,
	parameter int DATA_W = asr_pkg::DATA_W
) (
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [DATA_W-1:0] reqWdata,
	output logic                   reqReady,
	output logic                   rspDone,
	output logic      [DATA_W-1:0] rspRdata,
	output logic      [ADDR_W-1:0] memAddr,
	output logic                   memChipEn_n,
	output logic                   memOutGate_n,
	output logic                   memStore_n,
	input  wire logic [DATA_W-1:0] memDataIn,
	output logic      [DATA_W-1:0] memDataOut,
	output logic                   memDataOe
);
	// pin widths are fixed and the strobe counter must hold the read length
	if (ADDR_W != asr_pkg::ADDR_W || DATA_W != asr_pkg::DATA_W) begin : g_width
		$error("asr_host: only 11 address and 8 data bits are served");
	end
	if (asr_pkg::READ_CYC + 2 > (1 << asr_pkg::CNT_W)) begin : g_count
		$error("asr_host: strobe counter too narrow for the read length");
	end

	asr_pkg::asr_state_t state_ff;
	asr_pkg::asr_state_t nxt_state;
	logic [asr_pkg::CNT_W-1:0] cnt_ff;
	logic [asr_pkg::CNT_W-1:0] nxt_cnt;
	logic [DATA_W-1:0]         rdSync;

	function automatic logic [asr_pkg::CNT_W-1:0] cyc(input int n);
		cyc = asr_pkg::CNT_W'(n - 1);
	endfunction : cyc

	// a counted state on its last cycle
	function automatic logic at_end(
		input asr_pkg::asr_state_t        st,
		input asr_pkg::asr_state_t        want,
		input logic [asr_pkg::CNT_W-1:0] n
	);
		at_end = (st == want) && (n == '0);
	endfunction : at_end

	// pins come back asynchronously; read data must pass two flops
	asr_sync #(
		.WIDTH (DATA_W)
	) u_sync (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.asyncIn (memDataIn),
		.syncOut (rdSync)
	);

	// read strobe is stretched by two extra cycles to cover the synchroniser
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
		case (state_ff)
			asr_pkg::ASR_IDLE: begin
				if (reqValid && reqWrite) begin
					nxt_state = asr_pkg::ASR_WSTRB;
					nxt_cnt   = cyc(asr_pkg::WRP_CYC);
				end else if (reqValid) begin
					nxt_state = asr_pkg::ASR_RSTRB;
					nxt_cnt   = cyc(asr_pkg::READ_CYC + 2);
				end
			end
			asr_pkg::ASR_RSTRB: begin
				if (cnt_ff == '0)
					nxt_state = asr_pkg::ASR_RDONE;
			end
			asr_pkg::ASR_RDONE: begin
				nxt_state = asr_pkg::ASR_GAP;
				nxt_cnt   = cyc(asr_pkg::DIS_CYC);
			end
			asr_pkg::ASR_WSTRB: begin
				if (cnt_ff == '0) begin
					nxt_state = asr_pkg::ASR_WEND;
					nxt_cnt   = cyc(asr_pkg::REC_CYC);
				end
			end
			asr_pkg::ASR_WEND: begin
				if (cnt_ff == '0)
					nxt_state = asr_pkg::ASR_IDLE;
			end
			asr_pkg::ASR_GAP: begin
				if (cnt_ff == '0)
					nxt_state = asr_pkg::ASR_IDLE;
			end
			default: begin
				nxt_state = asr_pkg::ASR_IDLE;
				nxt_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= asr_pkg::ASR_IDLE;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// address and write data latch at acceptance and stay put until idle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			memAddr    <= '0;
			memDataOut <= '0;
		end else if (state_ff == asr_pkg::ASR_IDLE && reqValid) begin
			memAddr    <= reqAddr;
			memDataOut <= reqWdata;
		end
	end

	// strobes: all high at rest, so the memory floats its pins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			memChipEn_n  <= 1'b1;
			memOutGate_n <= 1'b1;
			memStore_n   <= 1'b1;
			memDataOe    <= 1'b0;
		end else begin
			// one chip, enabled only during an access
			memChipEn_n  <= !(nxt_state == asr_pkg::ASR_RSTRB ||
				nxt_state == asr_pkg::ASR_WSTRB);
			// gate stays high through writes to avoid contention
			memOutGate_n <= (nxt_state != asr_pkg::ASR_RSTRB);
			// store falls with chip enable so the memory never drives
			memStore_n   <= (nxt_state != asr_pkg::ASR_WSTRB);
			// data held one cycle past the strobe rise for capture
			memDataOe    <= (nxt_state == asr_pkg::ASR_WSTRB ||
				nxt_state == asr_pkg::ASR_WEND);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rspRdata <= '0;
		end else if (at_end(state_ff, asr_pkg::ASR_RSTRB, cnt_ff)) begin
			rspRdata <= rdSync;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rspDone  <= 1'b0;
			reqReady <= 1'b0;
		end else begin
			rspDone  <= at_end(state_ff, asr_pkg::ASR_RSTRB, cnt_ff) ||
				at_end(state_ff, asr_pkg::ASR_WEND, cnt_ff);
			reqReady <= (nxt_state == asr_pkg::ASR_IDLE);
		end
	end

	// pin protocol checks
	no_contend_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		memDataOe |-> memOutGate_n)
		else $error("host drives data while output gate is low");
	gate_in_write_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!memStore_n |-> memOutGate_n && !memChipEn_n)
		else $error("output gate low during a write");
	store_with_ce_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$fell(memChipEn_n) && !memOutGate_n |-> memStore_n)
		else $error("store low with read gate at select");
	write_pulse_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$fell(memStore_n) |-> !memStore_n [*3])
		else $error("store pulse shorter than three cycles");
	data_hold_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memStore_n) |-> memDataOe)
		else $error("write data released with the strobe");
	addr_stable_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!memChipEn_n && !$fell(memChipEn_n) |-> $stable(memAddr))
		else $error("address moved during an access");
	read_len_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$fell(memOutGate_n) |-> !memOutGate_n [*6] ##1 memOutGate_n)
		else $error("read strobe not six cycles");
	// write data may stand one cycle past the chip enable rise, no longer
	idle_float_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		memChipEn_n |-> memStore_n && memOutGate_n &&
			(!memDataOe || $rose(memChipEn_n)))
		else $error("strobes active while deselected");
	wdata_stable_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		memDataOe && !$rose(memDataOe) |-> $stable(memDataOut))
		else $error("write data moved while driven");
	oe_with_store_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memDataOe) |-> $fell(memStore_n) && $fell(memChipEn_n))
		else $error("data driven outside a write select");
	write_len_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memDataOe) |-> memDataOe [*4] ##1 !memDataOe)
		else $error("write data not driven four cycles");
	store_rise_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memStore_n) |-> $rose(memChipEn_n))
		else $error("store and chip enable rise apart");
	read_gap_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memOutGate_n) |-> memChipEn_n [*4])
		else $error("select too soon after a read");
	read_quiet_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!memOutGate_n |-> !memDataOe && memStore_n && !memChipEn_n)
		else $error("host active on the pins during a read");
	addr_hold_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memChipEn_n) |-> $stable(memAddr))
		else $error("address moved at deselect");
	ce_release_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(memChipEn_n) |-> memChipEn_n [*2])
		else $error("chip enable high for under two cycles");
	ready_idle_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		reqReady |-> memChipEn_n && memStore_n && memOutGate_n)
		else $error("ready shown during an access");
	gate_with_ce_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$fell(memOutGate_n) |-> $fell(memChipEn_n) && !memDataOe)
		else $error("read gate fell apart from chip enable");
	rdata_hold_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!rspDone |-> $stable(rspRdata))
		else $error("read data moved without done");
endmodule : asr_host
`default_nettype wire

//--- rtl/asr_sync.sv
// two-flop synchroniser for the data pins read back from the memory
// assumes the input is asynchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module asr_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_ff;

	if (WIDTH < 1) begin : g_width
		$error("asr_sync: width must be at least one");
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= '0;
			syncOut <= '0;
		end else begin
			meta_ff <= asyncIn;
			syncOut <= meta_ff;
		end
	end
endmodule : asr_sync
`default_nettype wire

//--- tb/asr_host_bench.sv
// self-checking bench for the static ram host controller
// assumes the model above is the only device on the data pins
`timescale 1ns/10ps
`default_nettype none
module asr_host_bench;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic [10:0] reqAddr = 11'h000;
	logic [7:0]  reqWdata = 8'h00;
	logic        reqReady, rspDone, ceN, ogN, stN, oe, mOe, pce;
	logic [7:0]  rspRdata, dOut, mOut, dq;
	logic [7:0]  pat = 8'hA5;
	logic [10:0] memAddr, pa;
	logic [8:0]  e;
	logic [8:0]  expQ [$];
	logic [7:0]  refMem [2048];
	int          err_count = 0;
	int          check_count = 0;

	always #25 mclk = ~mclk;
	// a released wire shows a changing pattern, never the last value
	always @(posedge mclk) pat <= ~pat;
	assign dq = oe ? dOut : (mOe ? mOut : pat);

	asr_host uut (.mclk(mclk), .arst_n(arst_n), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
		.reqReady(reqReady), .rspDone(rspDone), .rspRdata(rspRdata),
		.memAddr(memAddr), .memChipEn_n(ceN), .memOutGate_n(ogN),
		.memStore_n(stN), .memDataIn(dq), .memDataOut(dOut), .memDataOe(oe));
	asr_sram_model sram (.addr(memAddr), .ceN(ceN), .ogN(ogN), .stN(stN),
		.dq(dq), .dqOut(mOut), .dqOe(mOe));

	task automatic chk(input string w, input logic [10:0] x,
		input logic [10:0] s);
		check_count++;
		if (s !== x) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, x, s);
		end
	endtask : chk

	task stop_test;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic access(input logic w, input logic [10:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 40) begin
			err_count++;
			stop_test();
		end
		if (w)
			refMem[a] = d;
		expQ.push_back({!w, refMem[a]});
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqWdata = d;
		@(negedge mclk);
		reqValid = 1'b0;
	endtask : access

	always @(negedge mclk) begin
		if (arst_n) begin
			chk("contention", 11'h000, {10'h000, oe & mOe});
			chk("gate in write", 11'h000, {10'h000, !stN & !ogN});
			if (!ceN && !pce)
				chk("address", pa, memAddr);
			if (rspDone === 1'b1) begin
				e = expQ.size() ? expQ.pop_front() : 9'h1FF;
				if (e[8])
					chk("read data", {3'h0, e[7:0]}, {3'h0, rspRdata});
			end
		end
		pce <= ceN;
		pa <= memAddr;
	end

	initial begin
		logic [10:0] adr [$];
		void'($urandom(49));
		repeat (10) @(negedge mclk);
		arst_n = 1'b1;
		access(1'b1, 11'h000, 8'h5A);
		access(1'b1, 11'h7FF, 8'hA5);
		access(1'b0, 11'h000, 8'h00);
		access(1'b0, 11'h7FF, 8'h00);
		for (int i = 0; i < 16; i++) begin
			adr.push_back(11'($urandom));
			access(1'b1, adr[i], 8'($urandom));
		end
		repeat (300) @(negedge mclk);
		foreach (adr[i]) access(1'b0, adr[i], 8'h00);
		for (int i = 0; i < 24; i++)
			access(1'($urandom), adr[$urandom % 16], 8'($urandom));
		access(1'b1, 11'h123, 8'h3C);
		arst_n = 1'b0;
		@(negedge mclk);
		chk("strobes in reset", 11'h007, {8'h00, ceN, ogN, stN});
		chk("oe in reset", 11'h000, {10'h000, oe});
		expQ.delete();
		arst_n = 1'b1;
		access(1'b1, 11'h123, 8'hC3);
		access(1'b0, 11'h123, 8'h00);
		for (int n = 0; n < 40 && expQ.size() > 0; n++) @(negedge mclk);
		if (expQ.size() > 0)
			err_count++;
		stop_test();
	end
endmodule : asr_host_bench
`default_nettype wire

//--- tb/asr_sram_model.sv
// behavioural 2048 x 8 asynchronous static ram standing on the host's pins
// assumes the bench resolves the shared data wire and feeds it back on dq
`timescale 1ns/10ps
`default_nettype none
module asr_sram_model #(
	parameter int ACC_NS = 180
) (
	input  wire logic [10:0] addr,
	input  wire logic        ceN,
	input  wire logic        ogN,
	input  wire logic        stN,
	input  wire logic [7:0]  dq,
	output logic      [7:0]  dqOut,
	output logic             dqOe
);
	logic [7:0] mem [2048];
	logic       ovl = 1'b0;
	logic       blk = 1'b0;
	logic       late = 1'b0;
	logic       drv;
	always @(ceN, stN) begin
		if (ovl && (ceN || stN))
			mem[addr] = dq;
		ovl = !ceN && !stN;
		if (ceN)
			blk = 1'b0;
		else if (!stN)
			blk = 1'b1;
	end
	assign drv = !ceN && !ogN && stN && !blk;
	always @(drv)
		late <= #(ACC_NS) drv;
	// junk on the pins until the access time has run out
	assign dqOut = late ? mem[addr] : ~mem[addr];
	assign dqOe  = drv;
endmodule : asr_sram_model
`default_nettype wire
